// ===== design/ram_test_consts.svh
// Purpose: Named offsets, fields, commands and timing of the RAM self test block
// Assumes: 32-bit Avalon-MM register words, byte addresses, index = address / 4
// Notes: Definitions only; included by bare name
`ifndef RAM_TEST_CONSTS_SVH
`define RAM_TEST_CONSTS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_W 6
`define REG_CMD 6'h00
`define REG_STATUS 6'h01
`define REG_MISC 6'h02
`define REG_INT_STAT 6'h03
`define REG_INT_MASK 6'h04
`define REG_FAULT 6'h05

// ----------------------------------------
// Commands and fields
// ----------------------------------------
`define CMD_W 8
`define CMD_START 8'h01
`define CMD_SOFT_RST 8'h02
`define STAT_RUN_BIT 14
`define MISC_FAIL_BIT 0
`define INT_W 2
`define INT_DONE_BIT 0
`define INT_FAIL_BIT 1

// ----------------------------------------
// Timing and default sizes
// ----------------------------------------
`define TEST_TIME_MS 1
`define CLK_KHZ 20000
`define NUM_ARRAYS_DEF 4
`define RAM_AW_DEF 6
`define RAM_DW_DEF 16

`endif

// ===== design/ram_test_pkg.sv
// Purpose: Types shared by the RAM self test files
// Assumes: Nothing beyond the consts header
// Notes: Sequencer states only
package ram_test_pkg;

  // Sequencer states of one test run
  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ, ST_HOLD} test_state_t;

endpackage

// ===== design/self_test_ram.sv
// Purpose: One internal RAM array under test, single port, registered read
// Assumes: Same clock and clock enable as the sequencer
// Notes: Array content has no reset, only the read register does
`timescale 1ns/1ns
module self_test_ram
#(
  parameter int AW = 6,
  parameter int DW = 16
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Write port; storage is frozen with the clock enable
  always_ff @(posedge clk)
  begin
    if (ce && we)
      mem[addr] <= wdata;
  end

  // Read data leave through a register, one cycle after the address
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= '0;
    else if (ce)
      rdata <= mem[addr];
  end

endmodule // self_test_ram

// ===== design/ram_array_self_test.sv
// Purpose: RAM array self test controller with an Avalon-MM register slave
// Assumes: One clock CLK_SYS at 20 MHz, async active-low RSTN, CE freezes all state
// Notes: All arrays are swept in parallel, then the run is held to its full time
//
// What this block does
// R1 - Software starts and watches the self test only through the register port.
// R2 - A run sweeps every RAM array and ends only after the last array is checked.
// R3 - The overall result fails when any single array fails.
// R4 - Software resets the chip (power-on or soft reset) and then writes the start command.
// R5 - Status bit 14 reads one while the test runs and zero once it is over.
// R6 - Software polls the status register until the running bit is zero, then reads the result.
// R7 - Bit 0 of the misc status register gives the outcome, zero pass and one fail.
// R8 - A whole run takes 1 ms from the start command until the running bit clears.
// R9 - The result holds until the next reset or start, and starts are ignored while running.
`timescale 1ns/1ns
`include "ram_test_consts.svh"
module ram_array_self_test
  import ram_test_pkg::*;
#(
  parameter int NUM_ARRAYS = `NUM_ARRAYS_DEF,
  parameter int AW = `RAM_AW_DEF,
  parameter int DW = `RAM_DW_DEF,
  parameter int TEST_CYCLES = `TEST_TIME_MS * `CLK_KHZ
)
(
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic IRQ
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic irq_reg;
  test_state_t state_reg;
  logic running_reg;
  logic [31:0] timer_reg;
  logic [AW-1:0] addr_reg;
  logic [AW-1:0] rd_addr_reg;
  logic rd_valid_reg;
  logic fail_reg;
  logic swept_reg;
  logic result_reg;
  logic [`INT_W-1:0] int_stat_reg;
  logic [`INT_W-1:0] int_mask_reg;
  logic [`INT_W-1:0] int_set;
  logic [`INT_W-1:0] int_clr;
  logic [NUM_ARRAYS-1:0] fault_reg;
  logic [NUM_ARRAYS-1:0] mismatch;
  logic wr_acc;
  logic start_cmd;
  logic soft_cmd;
  logic done_evt;

  // Register decode, shared by the read mux and every write path
  function automatic logic hits(input logic [7:0] a, input logic [`IDX_W-1:0] idx);
    hits = (a[7:2] == idx);
  endfunction

  // Pattern depends on the address so stuck and coupled cells both show
  function automatic logic [DW-1:0] test_pattern(input logic [AW-1:0] a);
    test_pattern = DW'(a) ^ {DW{a[0]}};
  endfunction

  assign AVS_READDATA = rdata_reg;
  assign AVS_WAITREQUEST = wait_reg;
  assign IRQ = irq_reg;

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  // A write takes effect on the edge where waitrequest is seen low
  assign wr_acc = CE && AVS_WRITE && !wait_reg;
  // R1 start by register
  assign start_cmd = wr_acc && hits(AVS_ADDRESS, `REG_CMD)
                     && (AVS_WRITEDATA[`CMD_W-1:0] == `CMD_START);
  // R4 soft reset command
  assign soft_cmd = wr_acc && hits(AVS_ADDRESS, `REG_CMD)
                    && (AVS_WRITEDATA[`CMD_W-1:0] == `CMD_SOFT_RST);

  // Read mux; unmapped words and the command word read as zero
  always_comb
  begin
    rdata_next = 32'h0;
    if (hits(AVS_ADDRESS, `REG_STATUS))
      // R5 running flag
      rdata_next[`STAT_RUN_BIT] = running_reg;
    else if (hits(AVS_ADDRESS, `REG_MISC))
      // R7 pass or fail
      rdata_next[`MISC_FAIL_BIT] = result_reg;
    else if (hits(AVS_ADDRESS, `REG_INT_STAT))
      rdata_next[`INT_W-1:0] = int_stat_reg;
    else if (hits(AVS_ADDRESS, `REG_INT_MASK))
      rdata_next[`INT_W-1:0] = int_mask_reg;
    else if (hits(AVS_ADDRESS, `REG_FAULT))
      rdata_next[NUM_ARRAYS-1:0] = fault_reg;
  end

  // Every access waits exactly one cycle; idle waitrequest stays high
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0;
    end
    else if (CE)
    begin
      if ((AVS_READ || AVS_WRITE) && wait_reg)
      begin
        wait_reg <= 1'b0;
        rdata_reg <= rdata_next;
      end
      else
        wait_reg <= 1'b1;
    end
  end

  // Mask and fault-injection registers
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      int_mask_reg <= '0;
      fault_reg <= '0;
    end
    else if (wr_acc && hits(AVS_ADDRESS, `REG_INT_MASK))
      int_mask_reg <= AVS_WRITEDATA[`INT_W-1:0];
    else if (wr_acc && hits(AVS_ADDRESS, `REG_FAULT))
      fault_reg <= AVS_WRITEDATA[NUM_ARRAYS-1:0];
  end

  // ----------------------------------------
  // Test sequencer
  // ----------------------------------------
  // R8 end of the timed run
  assign done_evt = CE && (state_reg == ST_HOLD) && (timer_reg == 32'(TEST_CYCLES - 1));

  // Write sweep, read sweep, then hold until the run time is used up
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_reg <= ST_IDLE;
      running_reg <= 1'b0;
      addr_reg <= '0;
    end
    else if (CE)
    begin
      if (soft_cmd)
      begin
        state_reg <= ST_IDLE;
        running_reg <= 1'b0;
        addr_reg <= '0;
      end
      else
        unique case (state_reg)
          ST_IDLE:
            // R9 start only when idle
            if (start_cmd)
            begin
              state_reg <= ST_WRITE;
              running_reg <= 1'b1;
              addr_reg <= '0;
            end
          ST_WRITE:
          begin
            addr_reg <= addr_reg + 1'b1;
            if (&addr_reg)
              state_reg <= ST_READ;
          end
          ST_READ:
          begin
            addr_reg <= addr_reg + 1'b1;
            if (&addr_reg)
              state_reg <= ST_HOLD;
          end
          ST_HOLD:
            // R5 clear when done
            if (done_evt)
            begin
              state_reg <= ST_IDLE;
              running_reg <= 1'b0;
            end
        endcase
    end
  end

  // R8 run timer counts every cycle of the run
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      timer_reg <= 32'h0;
    else if (CE)
    begin
      if (state_reg == ST_IDLE || soft_cmd)
        timer_reg <= 32'h0;
      else
        timer_reg <= timer_reg + 32'h1;
    end
  end

  // ----------------------------------------
  // Arrays under test
  // ----------------------------------------
  // R2 every array tested
  for (genvar g = 0; g < NUM_ARRAYS; g++)
  begin : g_arr
    logic [DW-1:0] rdata;
    self_test_ram #(.AW(AW), .DW(DW)) u_ram (
      .clk(CLK_SYS),
      .rstn(RSTN),
      .ce(CE),
      .we(state_reg == ST_WRITE),
      .addr(addr_reg),
      .wdata(test_pattern(addr_reg) ^ {DW{fault_reg[g]}}),
      .rdata(rdata)
    );
    assign mismatch[g] = (rdata != test_pattern(rd_addr_reg));
  end

  // Compare runs one cycle behind the read address
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rd_valid_reg <= 1'b0;
      rd_addr_reg <= '0;
    end
    else if (CE)
    begin
      rd_valid_reg <= (state_reg == ST_READ) && !soft_cmd;
      rd_addr_reg <= addr_reg;
    end
  end

  // Fail and sweep-complete flags of the current run
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      fail_reg <= 1'b0;
      swept_reg <= 1'b0;
    end
    else if (CE)
    begin
      if (start_cmd && state_reg == ST_IDLE)
      begin
        fail_reg <= 1'b0;
        swept_reg <= 1'b0;
      end
      else if (rd_valid_reg)
      begin
        // R3 OR of array fails
        if (|mismatch)
          fail_reg <= 1'b1;
        if (&rd_addr_reg)
          swept_reg <= 1'b1;
      end
    end
  end

  // R7 result latched at the end; R9 held until reset or start
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      result_reg <= 1'b0;
    else if (CE)
    begin
      if (soft_cmd || (start_cmd && state_reg == ST_IDLE))
        result_reg <= 1'b0;
      else if (done_evt)
        result_reg <= fail_reg;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign int_set = {done_evt && fail_reg, done_evt};
  assign int_clr = (wr_acc && hits(AVS_ADDRESS, `REG_INT_STAT))
                   ? AVS_WRITEDATA[`INT_W-1:0] : '0;

  // Sticky bits; a new event wins over a write-one clear in the same cycle
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      int_stat_reg <= '0;
      irq_reg <= 1'b0;
    end
    else if (CE)
    begin
      int_stat_reg <= (int_stat_reg & ~int_clr) | int_set;
      irq_reg <= |(int_stat_reg & int_mask_reg);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_start;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (start_cmd && state_reg == ST_IDLE) |=> (running_reg && state_reg == ST_WRITE);
  endproperty
  // R1 start takes effect
  a_start: assert property (p_start) else $error("Start command did not start a run"); // R1

  property p_swept;
    @(posedge CLK_SYS) disable iff (!RSTN)
    ($fell(running_reg) && !$past(soft_cmd)) |-> swept_reg;
  endproperty
  // R2 all addresses checked
  a_swept: assert property (p_swept) else $error("Run ended before the sweep finished"); // R2

  property p_or_fail;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (CE && rd_valid_reg && |mismatch && !(start_cmd && state_reg == ST_IDLE)) |=> fail_reg;
  endproperty
  // R3 single fail counts
  a_or_fail: assert property (p_or_fail) else $error("Array mismatch did not mark fail"); // R3

  property p_run_bit;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (CE && AVS_READ && wait_reg && hits(AVS_ADDRESS, `REG_STATUS))
      |=> AVS_READDATA[`STAT_RUN_BIT] == $past(running_reg);
  endproperty
  // R5 status bit shows run
  a_run_bit: assert property (p_run_bit) else $error("Status bit 14 does not show run"); // R5

  property p_result;
    @(posedge CLK_SYS) disable iff (!RSTN)
    done_evt |=> (result_reg == $past(fail_reg));
  endproperty
  // R7 result matches fail
  a_result: assert property (p_result) else $error("Result bit differs from fail flag"); // R7

  property p_run_time;
    @(posedge CLK_SYS) disable iff (!RSTN)
    ($fell(running_reg) && !$past(soft_cmd)) |-> $past(timer_reg) == 32'(TEST_CYCLES - 1);
  endproperty
  // R8 full run time
  a_run_time: assert property (p_run_time) else $error("Run did not last the set time"); // R8

  property p_hold;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (!CE || (!soft_cmd && !start_cmd && !done_evt)) |=> $stable(result_reg);
  endproperty
  // R9 result stable
  a_hold: assert property (p_hold) else $error("Result changed without cause"); // R9

endmodule // ram_array_self_test

// ===== testbench/mgmt_master_model.sv
// Purpose: Management processor model, Avalon-MM master for the register port
// Assumes: One access at a time, signals change only after a rising edge
// Notes: Released address and data lines show the inverse of the last value; read and write go low
`timescale 1ns/1ns
module mgmt_master_model
(
  input wire logic clk,
  output logic [7:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  initial
  begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
  end

  // ----------------------------------------
  // Bus access
  // ----------------------------------------
  // start and polling travel only as bus accesses
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    // Hold the request until the slave drops waitrequest
    do
      @(posedge clk);
    while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    address <= ~a;
    writedata <= ~d;
  endtask
endmodule // mgmt_master_model

// ===== testbench/tb_ram_array_self_test.sv
// Purpose: Self-checking bench for the RAM self test controller
// Assumes: Short run length of 200 cycles, CE held high
// Notes: Cycle counts measured from the edge the start write lands
`timescale 1ns/1ns
`include "ram_test_consts.svh"
module tb_ram_array_self_test;
  localparam int TC = 200;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] q;

  ram_array_self_test #(.TEST_CYCLES(TC)) ram_array_self_test_i (
    .CLK_SYS(clk_sys), .RSTN(rstn), .CE(ce), .AVS_ADDRESS(address), .AVS_READ(read),
    .AVS_WRITE(write), .AVS_WRITEDATA(writedata), .AVS_READDATA(readdata),
    .AVS_WAITREQUEST(waitrequest), .IRQ(irq));
  mgmt_master_model mgmt_master_model_i (
    .clk(clk_sys), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));

  // Clock and free cycle count
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] dummy;
    mgmt_master_model_i.access(1'b1, {idx, 2'b00}, d, dummy);
  endtask

  task automatic rd(input logic [5:0] idx, output logic [31:0] d);
    mgmt_master_model_i.access(1'b0, {idx, 2'b00}, 32'h0, d);
  endtask

  // Start a run, then poll the running bit until it drops
  task automatic run_and_wait(input bit restart);
    int t0;
    int n;
    wr(`REG_CMD, {24'h0, `CMD_START});
    t0 = cyc;
    rd(`REG_STATUS, q);
    check("running bit", 32'h1, {31'h0, q[`STAT_RUN_BIT]});
    if (restart)
      wr(`REG_CMD, {24'h0, `CMD_START});
    n = 0;
    do
    begin
      rd(`REG_STATUS, q);
      n++;
    end
    while (q[`STAT_RUN_BIT] !== 1'b0 && n < 400);
    check("run cycles", 32'h1, {31'h0, (cyc - t0 >= TC) && (cyc - t0 <= TC + 6)});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_values;
    rd(`REG_STATUS, q);
    check("status after reset", 32'h0, q);
    rd(`REG_MISC, q);
    check("misc after reset", 32'h0, q);
    rd(6'h10, q);
    check("unmapped read", 32'h0, q);
    check("irq after reset", 32'h0, {31'h0, irq});
  endtask

  task automatic t_pass;
    wr(`REG_INT_MASK, 32'h3);
    wr(`REG_FAULT, 32'h0);
    run_and_wait(1'b0);
    rd(`REG_MISC, q);
    check("pass result", 32'h0, {31'h0, q[`MISC_FAIL_BIT]});
    rd(`REG_INT_STAT, q);
    check("done event", 32'h1, q);
    check("irq raised", 32'h1, {31'h0, irq});
    wr(`REG_INT_STAT, 32'h3);
    repeat (2) @(posedge clk_sys);
    check("irq cleared", 32'h0, {31'h0, irq});
  endtask

  task automatic t_fail_restart;
    wr(`REG_INT_MASK, 32'h0);
    wr(`REG_FAULT, 32'h4);
    rd(`REG_FAULT, q);
    check("fault readback", 32'h4, q);
    rd(`REG_INT_MASK, q);
    check("mask readback", 32'h0, q);
    run_and_wait(1'b1);
    rd(`REG_MISC, q);
    check("fail result", 32'h1, {31'h0, q[`MISC_FAIL_BIT]});
    rd(`REG_INT_STAT, q);
    check("fail event", 32'h3, q);
    check("irq masked", 32'h0, {31'h0, irq});
    repeat (50) @(posedge clk_sys);
    rd(`REG_MISC, q);
    check("result held", 32'h1, {31'h0, q[`MISC_FAIL_BIT]});
    wr(`REG_CMD, {24'h0, `CMD_SOFT_RST});
    rd(`REG_MISC, q);
    check("result after soft reset", 32'h0, q);
  endtask

  // ----------------------------------------
  // Verdict and main sequence
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset_values();
    t_pass();
    t_fail_restart();
    report_and_stop();
  end

  // Watchdog well beyond two runs of TC cycles
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    report_and_stop();
  end
endmodule // tb_ram_array_self_test
